// *** logic/pm_port_mux.sv ***
// pin function mux and general i/o for ports 1 to 6, with axi4-lite registers
// assumes pads are asynchronous, peripherals share clk_i, reset is synchronous
//
// Register access over AXI4-Lite was chosen for this implementation.
`default_nettype none

// Functional notes
// - With select 0 a pin is general i/o: direction 0 input, direction 1 output.
// - With select 1 a timer pin feeds the timer input at direction 0, drives it at 1.
// - A port 2 comparator-disable bit at 1 hands the pin to the analog input.
// - The oscillator resistor select at 1 gives port 2 pin 5 to the resistor.
// - A port 3 pin given to the serial module takes its direction from that module.
// - The async serial clock beats the slave enable and forces 4-wire spi to 3-wire.
// - A pin carrying i2c only ever drives low, open-drain style.
// - Only ports 1 and 2 have interrupt enable, edge and flag registers.
// - Every port has a pull-enable register besides level, drive, direction, select.
module pm_port_mux (
	input wire logic clk_i, // 100 MHz block clock
	input wire logic reset_i, // synchronous reset, active high
	input wire pm_pkg::pm_axi_req_t axi_i, // axi4-lite request
	output pm_pkg::pm_axi_rsp_t axi_o, // axi4-lite answer
	input wire logic [5:0][7:0] pad_in_i, // pad levels, port 1 at index 0
	output logic [5:0][7:0] pad_out_o, // pad drive values
	output logic [5:0][7:0] pad_oe_o, // pad output enables
	output logic [5:0][7:0] pull_en_o, // pad pull resistor enables
	input wire pm_pkg::pm_periph_drive_t periph_i, // from peripherals
	output pm_pkg::pm_periph_sense_t sense_o, // to peripherals
	output logic irq_o // level interrupt
);

	pm_pkg::pm_state_t st;
	pm_pkg::pm_state_t next_st;
	logic [5:0][7:0] lvl;
	logic [5:0][7:0] rise;
	logic [5:0][7:0] fall;

	// synchronise every port
	for (genvar p = 0; p < 6; p++) begin : g_sync
		pm_pin_sync u_sync (
			.clk_i(clk_i),
			.reset_i(reset_i),
			.pad_i(pad_in_i[p]),
			.level_o(lvl[p]),
			.rise_o(rise[p]),
			.fall_o(fall[p])
		);
	end

	// bus slave, registers, flags and pin steering
	always_comb begin
		logic hit;
		logic rhit;
		logic [7:0] rd;
		logic [1:0][7:0] w1c;
		logic [1:0][7:0] edge_set;
		logic [7:0] sel;
		logic [7:0] dir;
		logic [7:0] po;
		logic [7:0] analog;
		logic [7:0] capt;
		hit = 1'b0;
		rhit = 1'b0;
		rd = pm_pkg::PM_RESET_BYTE;
		w1c = '0;
		edge_set = '0;
		sel = '0;
		dir = '0;
		po = '0;
		analog = '0;
		capt = '0;
		next_st = st;

		// write address and data taken in either order
		if (axi_i.awvalid && !st.aw_held) begin
			next_st.aw_held = 1'b1;
			next_st.aw_addr = axi_i.awaddr;
		end
		if (axi_i.wvalid && !st.w_held) begin
			next_st.w_held = 1'b1;
			next_st.w_data = axi_i.wdata[7:0];
			next_st.w_lane0 = axi_i.wstrb[0];
		end
		if (st.bvalid && axi_i.bready) begin
			next_st.bvalid = 1'b0;
		end

		// register write once both halves are held
		if (st.aw_held && st.w_held && !st.bvalid) begin
			next_st.aw_held = 1'b0;
			next_st.w_held = 1'b0;
			next_st.bvalid = 1'b1;
			for (int p = 0; p < 6; p++) begin
				if (pm_pkg::pm_hit(st.aw_addr, pm_pkg::PM_IDX_LEVEL[p])) begin
					hit = 1'b1;
				end
				if (pm_pkg::pm_hit(st.aw_addr, pm_pkg::PM_IDX_DRIVE[p])) begin
					hit = 1'b1;
					if (st.w_lane0) next_st.drive_value[p] = st.w_data;
				end
				if (pm_pkg::pm_hit(st.aw_addr, pm_pkg::PM_IDX_DIR[p])) begin
					hit = 1'b1;
					if (st.w_lane0) next_st.direction[p] = st.w_data;
				end
				if (pm_pkg::pm_hit(st.aw_addr, pm_pkg::PM_IDX_SEL[p])) begin
					hit = 1'b1;
					if (st.w_lane0) next_st.function_select[p] = st.w_data;
				end
				if (pm_pkg::pm_hit(st.aw_addr, pm_pkg::PM_IDX_PULL[p])) begin
					hit = 1'b1;
					if (st.w_lane0) next_st.pull_enable[p] = st.w_data;
				end
			end
			// interrupt registers exist for ports 1 and 2 only
			for (int q = 0; q < 2; q++) begin
				if (pm_pkg::pm_hit(st.aw_addr, pm_pkg::PM_IDX_IRQ_FLAGS[q])) begin
					hit = 1'b1;
					if (st.w_lane0) w1c[q] = st.w_data;
				end
				if (pm_pkg::pm_hit(st.aw_addr, pm_pkg::PM_IDX_IRQ_EDGE[q])) begin
					hit = 1'b1;
					if (st.w_lane0) next_st.irq_edge[q] = st.w_data;
				end
				if (pm_pkg::pm_hit(st.aw_addr, pm_pkg::PM_IDX_IRQ_ENABLE[q])) begin
					hit = 1'b1;
					if (st.w_lane0) next_st.irq_enable[q] = st.w_data;
				end
			end
			if (pm_pkg::pm_hit(st.aw_addr, pm_pkg::PM_IDX_COMP_DISABLE)) begin
				hit = 1'b1;
				if (st.w_lane0) next_st.comparator_pin_disable = st.w_data;
			end
			if (pm_pkg::pm_hit(st.aw_addr, pm_pkg::PM_IDX_OSC_SELECT)) begin
				hit = 1'b1;
				if (st.w_lane0) next_st.osc_resistor_select = st.w_data[0];
			end
			next_st.bresp = hit ? pm_pkg::PM_RESP_OKAY : pm_pkg::PM_RESP_SLVERR;
		end

		// read: data captured when the address is taken
		if (st.rvalid && axi_i.rready) begin
			next_st.rvalid = 1'b0;
		end
		if (axi_i.arvalid && !st.rvalid) begin
			for (int p = 0; p < 6; p++) begin
				if (pm_pkg::pm_hit(axi_i.araddr, pm_pkg::PM_IDX_LEVEL[p])) begin
					rhit = 1'b1;
					rd = lvl[p];
				end
				if (pm_pkg::pm_hit(axi_i.araddr, pm_pkg::PM_IDX_DRIVE[p])) begin
					rhit = 1'b1;
					rd = st.drive_value[p];
				end
				if (pm_pkg::pm_hit(axi_i.araddr, pm_pkg::PM_IDX_DIR[p])) begin
					rhit = 1'b1;
					rd = st.direction[p];
				end
				if (pm_pkg::pm_hit(axi_i.araddr, pm_pkg::PM_IDX_SEL[p])) begin
					rhit = 1'b1;
					rd = st.function_select[p];
				end
				if (pm_pkg::pm_hit(axi_i.araddr, pm_pkg::PM_IDX_PULL[p])) begin
					rhit = 1'b1;
					rd = st.pull_enable[p];
				end
			end
			for (int q = 0; q < 2; q++) begin
				if (pm_pkg::pm_hit(axi_i.araddr, pm_pkg::PM_IDX_IRQ_FLAGS[q])) begin
					rhit = 1'b1;
					rd = st.irq_flags[q];
				end
				if (pm_pkg::pm_hit(axi_i.araddr, pm_pkg::PM_IDX_IRQ_EDGE[q])) begin
					rhit = 1'b1;
					rd = st.irq_edge[q];
				end
				if (pm_pkg::pm_hit(axi_i.araddr, pm_pkg::PM_IDX_IRQ_ENABLE[q])) begin
					rhit = 1'b1;
					rd = st.irq_enable[q];
				end
			end
			if (pm_pkg::pm_hit(axi_i.araddr, pm_pkg::PM_IDX_COMP_DISABLE)) begin
				rhit = 1'b1;
				rd = st.comparator_pin_disable;
			end
			if (pm_pkg::pm_hit(axi_i.araddr, pm_pkg::PM_IDX_OSC_SELECT)) begin
				rhit = 1'b1;
				rd = {7'h00, st.osc_resistor_select};
			end
			next_st.rvalid = 1'b1;
			next_st.rdata = {24'h00_0000, rd};
			next_st.rresp = rhit ? pm_pkg::PM_RESP_OKAY : pm_pkg::PM_RESP_SLVERR;
		end

		// edge flags: a set in the clearing cycle wins
		for (int q = 0; q < 2; q++) begin
			edge_set[q] = (~st.irq_edge[q] & rise[q]) | (st.irq_edge[q] & fall[q]);
			next_st.irq_flags[q] = (st.irq_flags[q] & ~w1c[q]) | edge_set[q];
		end

		// general i/o default for every pin
		for (int p = 0; p < 6; p++) begin
			next_st.pad_out[p] = st.drive_value[p];
			next_st.pad_oe[p] = st.direction[p];
		end

		// port 1: timer a, submain and converter clocks
		sel = st.function_select[0];
		dir = st.direction[0];
		po = {periph_i.timer_a_out, periph_i.submain_clock_out, periph_i.timer_a_out,
			periph_i.converter_clock_out};
		next_st.pad_out[0] = (sel & po) | (~sel & st.drive_value[0]);
		capt = lvl[0] & sel & ~dir;
		next_st.sense.first_timer_clock_in = capt[0];
		next_st.sense.timer_a_capture_in = capt[3:1];

		// port 2: comparator inputs and oscillator resistor override all
		sel = st.function_select[1];
		dir = st.direction[1];
		po = {periph_i.timer_a_out[0], periph_i.converter_clock_out, 1'b0,
			periph_i.timer_a_out[2], periph_i.timer_a_out[1],
			periph_i.comparator_result_out, 1'b0, periph_i.aux_clock_out};
		analog = st.comparator_pin_disable;
		analog[pm_pkg::PM_OSC_PIN] = analog[pm_pkg::PM_OSC_PIN] | st.osc_resistor_select;
		next_st.pad_out[1] = (sel & po) | (~sel & st.drive_value[1]);
		next_st.pad_oe[1] = dir & ~analog;
		capt = lvl[1] & sel & ~dir & ~analog;
		next_st.sense.timer_a_inclk_in = capt[1];
		next_st.sense.timer_a_cci0b_in = capt[2];
		next_st.sense.transfer_trigger_in = capt[6];
		next_st.sense.comparator_pin_enable = st.comparator_pin_disable;
		next_st.sense.external_oscillator_resistor = st.osc_resistor_select;

		// port 3: serial module owns direction of selected pins
		sel = st.function_select[2];
		next_st.pad_out[2] = (sel & periph_i.serial_out) | (~sel & st.drive_value[2]);
		next_st.pad_oe[2] = (sel & periph_i.serial_oe) | (~sel & st.direction[2]);
		for (int k = 1; k < 3; k++) begin
			if (sel[k] && periph_i.serial_i2c[k - 1]) begin
				next_st.pad_out[2][k] = 1'b0;
				next_st.pad_oe[2][k] = periph_i.serial_oe[k] & ~periph_i.serial_out[k];
			end
		end
		next_st.sense.serial_in = lvl[2] & sel;
		next_st.sense.async_side_serial_clock = lvl[2][0] & sel[0] & periph_i.async_clk_needed;
		next_st.sense.sync_side_slave_enable = lvl[2][0] & sel[0]
			& ~periph_i.async_clk_needed;
		next_st.sense.spi_four_wire_eff = periph_i.spi_four_wire_req
			& ~periph_i.async_clk_needed;

		// port 4: timer b outputs and clock input
		sel = st.function_select[3];
		dir = st.direction[3];
		po = {1'b0, periph_i.timer_b_out};
		next_st.pad_out[3] = (sel & po) | (~sel & st.drive_value[3]);
		capt = lvl[3] & sel & ~dir;
		next_st.sense.timer_b_capture_in = capt[6:0];
		next_st.sense.second_timer_clock_in = capt[7];

		// ports 5 and 6: a selected pin is released to outside users
		for (int p = 4; p < 6; p++) begin
			next_st.pad_oe[p] = st.direction[p] & ~st.function_select[p];
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// bus handshakes and registered outputs
	assign axi_o.awready = !st.aw_held;
	assign axi_o.wready = !st.w_held;
	assign axi_o.bvalid = st.bvalid;
	assign axi_o.bresp = st.bresp;
	assign axi_o.arready = !st.rvalid;
	assign axi_o.rvalid = st.rvalid;
	assign axi_o.rdata = st.rdata;
	assign axi_o.rresp = st.rresp;
	assign pad_out_o = st.pad_out;
	assign pad_oe_o = st.pad_oe;
	assign pull_en_o = st.pull_enable;
	assign sense_o = st.sense;
	// only ports 1 and 2 can interrupt
	assign irq_o = |(st.irq_flags & st.irq_enable);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	// general i/o direction follows the direction register
	property p_gpio_dir;
		(st.function_select[0] == 8'h00) |=> (pad_oe_o[0] == $past(st.direction[0]))
			&& (pad_out_o[0] == $past(st.drive_value[0]));
	endproperty
	a_gpio_dir: assert property (p_gpio_dir) else $error("gpio direction wrong");

	// timer b capture fed from the pin level
	property p_timer_capture;
		(st.function_select[3][0] && !st.direction[3][0])
			|=> sense_o.timer_b_capture_in[0] == $past(lvl[3][0]);
	endproperty
	a_timer_capture: assert property (p_timer_capture) else $error("timer capture wrong");

	// comparator disable releases the pad
	property p_comp_disable;
		st.comparator_pin_disable[2] |=> !pad_oe_o[1][2] && sense_o.comparator_pin_enable[2];
	endproperty
	a_comp_disable: assert property (p_comp_disable) else $error("comparator pin driven");

	// oscillator resistor takes port 2 pin 5
	property p_osc_res;
		st.osc_resistor_select |=> !pad_oe_o[1][5] && sense_o.external_oscillator_resistor;
	endproperty
	a_osc_res: assert property (p_osc_res) else $error("oscillator pin driven");

	// input-only pin drives ground
	property p_input_gnd;
		(st.function_select[1][1] && st.direction[1][1] && !st.comparator_pin_disable[1])
			|=> pad_oe_o[1][1] && !pad_out_o[1][1];
	endproperty
	a_input_gnd: assert property (p_input_gnd) else $error("input-only pin not grounded");

	// serial module steers direction
	property p_serial_dir;
		(st.function_select[2][4]) |=> pad_oe_o[2][4] == $past(periph_i.serial_oe[4]);
	endproperty
	a_serial_dir: assert property (p_serial_dir) else $error("serial direction wrong");

	// async clock wins and forces 3-wire
	property p_clk_priority;
		periph_i.async_clk_needed |=> !sense_o.spi_four_wire_eff && !sense_o.sync_side_slave_enable;
	endproperty
	a_clk_priority: assert property (p_clk_priority) else $error("clock priority wrong");

	// i2c pin never drives high
	property p_i2c_low;
		(st.function_select[2][1] && periph_i.serial_i2c[0]) |=> !pad_out_o[2][1];
	endproperty
	a_i2c_low: assert property (p_i2c_low) else $error("i2c pin driven high");

	// enabled rising edge reaches the interrupt
	property p_irq_edge;
		($rose(pad_in_i[0][0]) && st.irq_enable[0][0] && !st.irq_edge[0][0])
			##1 (st.irq_enable[0][0] && !st.irq_edge[0][0]) [*3] |-> ##[0:1] irq_o;
	endproperty
	a_irq_edge: assert property (p_irq_edge) else $error("edge interrupt missing");

endmodule

`default_nettype wire

// *** logic/pm_pkg.sv ***
// package for the port pin function mux: register indices, reset values, carriers
// assumes one 100 MHz clock and a synchronous active-high reset everywhere
`default_nettype none

package pm_pkg;

	// register indices; byte address on the bus is four times the index
	// port tables are ordered port6 .. port1 (element 0 is port 1)
	localparam logic [5:0][7:0] PM_IDX_LEVEL = {8'h34, 8'h30, 8'h1C, 8'h18, 8'h28, 8'h20};
	localparam logic [5:0][7:0] PM_IDX_DRIVE = {8'h35, 8'h31, 8'h1D, 8'h19, 8'h29, 8'h21};
	localparam logic [5:0][7:0] PM_IDX_DIR = {8'h36, 8'h32, 8'h1E, 8'h1A, 8'h2A, 8'h22};
	localparam logic [5:0][7:0] PM_IDX_SEL = {8'h37, 8'h33, 8'h1F, 8'h1B, 8'h2E, 8'h26};
	localparam logic [5:0][7:0] PM_IDX_PULL = {8'h13, 8'h12, 8'h11, 8'h10, 8'h2F, 8'h27};
	// interrupt registers, ports 2 and 1 only
	localparam logic [1:0][7:0] PM_IDX_IRQ_FLAGS = {8'h2B, 8'h23};
	localparam logic [1:0][7:0] PM_IDX_IRQ_EDGE = {8'h2C, 8'h24};
	localparam logic [1:0][7:0] PM_IDX_IRQ_ENABLE = {8'h2D, 8'h25};
	localparam logic [7:0] PM_IDX_COMP_DISABLE = 8'h5B;
	// oscillator resistor select, bit 0
	localparam logic [7:0] PM_IDX_OSC_SELECT = 8'h38;

	// field positions and reset values
	localparam int unsigned PM_OSC_PIN = 5;
	localparam logic [7:0] PM_RESET_BYTE = 8'h00;
	localparam logic [1:0] PM_RESP_OKAY = 2'h0;
	localparam logic [1:0] PM_RESP_SLVERR = 2'h2;

	typedef logic [7:0] pm_byte_t;

	// axi4-lite request from the master
	typedef struct packed {
		logic awvalid;
		logic [11:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [11:0] araddr;
		logic rready;
	} pm_axi_req_t;

	// axi4-lite answer of the slave
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} pm_axi_rsp_t;

	// signals the internal peripherals drive toward the pads
	typedef struct packed {
		logic [2:0] timer_a_out;
		logic [6:0] timer_b_out;
		logic submain_clock_out;
		logic converter_clock_out;
		logic comparator_result_out;
		logic aux_clock_out;
		logic [7:0] serial_out;
		logic [7:0] serial_oe;
		logic [1:0] serial_i2c;
		logic async_clk_needed;
		logic spi_four_wire_req;
	} pm_periph_drive_t;

	// signals the mux hands to the internal peripherals
	typedef struct packed {
		logic first_timer_clock_in;
		logic [2:0] timer_a_capture_in;
		logic timer_a_cci0b_in;
		logic timer_a_inclk_in;
		logic transfer_trigger_in;
		logic [6:0] timer_b_capture_in;
		logic second_timer_clock_in;
		logic [7:0] serial_in;
		logic async_side_serial_clock;
		logic sync_side_slave_enable;
		logic spi_four_wire_eff;
		logic [7:0] comparator_pin_enable;
		logic external_oscillator_resistor;
	} pm_periph_sense_t;

	// whole state of the mux block
	typedef struct packed {
		logic [5:0][7:0] drive_value;
		logic [5:0][7:0] direction;
		logic [5:0][7:0] function_select;
		logic [5:0][7:0] pull_enable;
		logic [1:0][7:0] irq_flags;
		logic [1:0][7:0] irq_edge;
		logic [1:0][7:0] irq_enable;
		logic [7:0] comparator_pin_disable;
		logic osc_resistor_select;
		logic aw_held;
		logic [11:0] aw_addr;
		logic w_held;
		logic [7:0] w_data;
		logic w_lane0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [5:0][7:0] pad_out;
		logic [5:0][7:0] pad_oe;
		pm_periph_sense_t sense;
	} pm_state_t;

	// state of one pin synchroniser
	typedef struct packed {
		logic [7:0] meta;
		logic [7:0] level;
		logic [7:0] prev;
	} pm_sync_state_t;

	// register hit: upper address bits zero, word index matches
	function automatic logic pm_hit(input logic [11:0] addr, input logic [7:0] idx);
		pm_hit = (addr[11:10] == 2'h0) && (addr[9:2] == idx);
	endfunction

endpackage

`default_nettype wire

// *** logic/pm_pin_sync.sv ***
// two-flop synchroniser for one 8-pin port with edge detection
// assumes pad levels arrive asynchronously to clk_i
`default_nettype none

module pm_pin_sync (
	input wire logic clk_i, // block clock
	input wire logic reset_i, // synchronous reset, active high
	input wire logic [7:0] pad_i, // raw pad levels
	output logic [7:0] level_o, // synchronised levels
	output logic [7:0] rise_o, // one-cycle rising edge
	output logic [7:0] fall_o // one-cycle falling edge
);

	pm_pkg::pm_sync_state_t st;
	pm_pkg::pm_sync_state_t next_st;

	// meta feeds the level stage, and in reset prev too, so prev shadows level and release shows no edge
	always_comb begin
		next_st = st;
		next_st.meta = pad_i;
		next_st.level = st.meta;
		next_st.prev = reset_i ? st.meta : st.level;
	end

	// pipeline keeps sampling in reset, so a pin idling high gives no false edge
	always_ff @(posedge clk_i) begin
		st <= next_st;
	end

	// edges seen between the two settled stages
	assign level_o = st.level;
	assign rise_o = st.level & ~st.prev;
	assign fall_o = ~st.level & st.prev;

endmodule

`default_nettype wire

// *** dv/pm_periph_model.sv ***
// peripheral stand-in: timer, clock and serial lines toward the mux
// assumes the bench picks the levels and everything shares clk_i
`default_nettype none

module pm_periph_model (
	input wire logic clk_i, // block clock
	input wire logic reset_i, // synchronous reset, active high
	input wire logic [7:0] pattern_i, // output levels to present
	input wire logic [7:0] oe_i, // serial pin enables
	input wire logic [1:0] i2c_i, // i2c on serial pins 1 and 2
	input wire logic [1:0] mode_i, // bit0 async clock needed, bit1 4-wire
	output pm_pkg::pm_periph_drive_t drive_o // toward the mux
);
	timeunit 1ns;
	timeprecision 1ps;

	// registered like real peripheral flops, so changes lag one edge
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			drive_o <= '0;
		end else begin
			drive_o.timer_a_out <= pattern_i[2:0];
			drive_o.timer_b_out <= pattern_i[6:0];
			drive_o.submain_clock_out <= pattern_i[0];
			drive_o.converter_clock_out <= pattern_i[1];
			drive_o.comparator_result_out <= pattern_i[2];
			drive_o.aux_clock_out <= pattern_i[3];
			drive_o.serial_out <= pattern_i;
			drive_o.serial_oe <= oe_i;
			drive_o.serial_i2c <= i2c_i;
			drive_o.async_clk_needed <= mode_i[0];
			drive_o.spi_four_wire_req <= mode_i[1];
		end
	end

endmodule

`default_nettype wire

// *** dv/test_port_pin_function_mux.sv ***
// bench for the pin mux: axi4-lite register tasks and pin checks
// assumes pm_port_mux and pm_periph_model, one 100 MHz clock
`default_nettype none

module test_port_pin_function_mux;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [1:0] OK = pm_pkg::PM_RESP_OKAY;
	localparam logic [1:0] SE = pm_pkg::PM_RESP_SLVERR;
	logic clk_i;
	logic reset_i;
	pm_pkg::pm_axi_req_t req;
	pm_pkg::pm_axi_rsp_t rsp;
	logic [5:0][7:0] ext, pad_w, pad_out, pad_oe, pull_en;
	logic [7:0] pattern, soe;
	logic [1:0] i2c, mode;
	pm_pkg::pm_periph_drive_t drive;
	pm_pkg::pm_periph_sense_t sense;
	logic irq;
	int err_total, n_tests;

	// driven pins show the block's value, released pins the outside level
	assign pad_w = (pad_out & pad_oe) | (ext & ~pad_oe);

	pm_port_mux pm_port_mux_i (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.axi_i(req),
		.axi_o(rsp),
		.pad_in_i(pad_w),
		.pad_out_o(pad_out),
		.pad_oe_o(pad_oe),
		.pull_en_o(pull_en),
		.periph_i(drive),
		.sense_o(sense),
		.irq_o(irq)
	);

	pm_periph_model pm_periph_model_i (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.pattern_i(pattern),
		.oe_i(soe),
		.i2c_i(i2c),
		.mode_i(mode),
		.drive_o(drive)
	);

	// free-running clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// write one word; address and data offered together, held until taken
	task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge clk_i);
		req.awaddr <= {2'h0, idx, 2'h0};
		req.wdata <= {24'h0, d};
		req.wstrb <= 4'hF;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge clk_i);
			if (rsp.awready && !aw_done) begin
				aw_done = 1'b1;
				req.awvalid <= 1'b0;
			end
			if (rsp.wready && !w_done) begin
				w_done = 1'b1;
				req.wvalid <= 1'b0;
			end
		end
		@(posedge clk_i);
		while (!rsp.bvalid) @(posedge clk_i);
		req.bready <= 1'b0;
		chk({6'h0, rsp.bresp}, {6'h0, er});
	endtask

	// read one word and compare data, upper zero bits and response
	task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] er);
		@(posedge clk_i);
		req.araddr <= {2'h0, idx, 2'h0};
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		@(posedge clk_i);
		while (!rsp.arready) @(posedge clk_i);
		req.arvalid <= 1'b0;
		@(posedge clk_i);
		while (!rsp.rvalid) @(posedge clk_i);
		req.rready <= 1'b0;
		chk(rsp.rdata[7:0], exp);
		chk(8'(|rsp.rdata[31:8]), 8'h00);
		chk({6'h0, rsp.rresp}, {6'h0, er});
	endtask

	task automatic summarize();
		$display("comparisons %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// cut a hang short well beyond the expected run length
	initial begin
		repeat (20000) @(posedge clk_i);
		err_total++;
		summarize();
	end

	// main sequence
	initial begin
		req = '0;
		ext = '0;
		pattern = 8'h00;
		soe = 8'h00;
		i2c = 2'h0;
		mode = 2'h0;
		err_total = 0;
		n_tests = 0;
		reset_i = 1'b1;
		repeat (12) @(posedge clk_i);
		reset_i <= 1'b0;
		// reset values, pull registers, read-only level registers
		for (int p = 0; p < 6; p++) begin
			rd_chk(pm_pkg::PM_IDX_DRIVE[p], pm_pkg::PM_RESET_BYTE, OK);
			rd_chk(pm_pkg::PM_IDX_DIR[p], pm_pkg::PM_RESET_BYTE, OK);
			rd_chk(pm_pkg::PM_IDX_SEL[p], pm_pkg::PM_RESET_BYTE, OK);
			wr(pm_pkg::PM_IDX_PULL[p], 8'h81 ^ 8'(p), OK);
			rd_chk(pm_pkg::PM_IDX_PULL[p], 8'h81 ^ 8'(p), OK);
			chk(pull_en[p], 8'h81 ^ 8'(p));
			wr(pm_pkg::PM_IDX_LEVEL[p], 8'hFF, OK);
			rd_chk(pm_pkg::PM_IDX_LEVEL[p], 8'h00, OK);
		end
		rd_chk(8'h40, 8'h00, SE);
		wr(8'h40, 8'hFF, SE);
		rd_chk(8'h14, 8'h00, SE);
		// port 4 general i/o, then timer pins
		ext[3] <= 8'h3C;
		wr(pm_pkg::PM_IDX_DRIVE[3], 8'h5A, OK);
		wr(pm_pkg::PM_IDX_DIR[3], 8'hF0, OK);
		tick(4);
		chk(pad_oe[3], 8'hF0);
		chk(pad_out[3] & 8'hF0, 8'h50);
		rd_chk(pm_pkg::PM_IDX_LEVEL[3], 8'h5C, OK);
		pattern <= 8'h35;
		wr(pm_pkg::PM_IDX_SEL[3], 8'h7F, OK);
		tick(4);
		chk(pad_out[3] & 8'hF0, 8'h30);
		chk({4'h0, sense.timer_b_capture_in[3:0]}, 8'h0C);
		// port 2 comparator, oscillator resistor, ground drive
		wr(pm_pkg::PM_IDX_DRIVE[1], 8'hFF, OK);
		wr(pm_pkg::PM_IDX_DIR[1], 8'hFF, OK);
		wr(pm_pkg::PM_IDX_COMP_DISABLE, 8'h9C, OK);
		tick(3);
		chk(pad_oe[1], 8'h63);
		chk(sense.comparator_pin_enable, 8'h9C);
		wr(pm_pkg::PM_IDX_OSC_SELECT, 8'h01, OK);
		tick(3);
		chk(pad_oe[1], 8'h43);
		chk({7'h0, sense.external_oscillator_resistor}, 8'h01);
		wr(pm_pkg::PM_IDX_COMP_DISABLE, 8'h00, OK);
		wr(pm_pkg::PM_IDX_OSC_SELECT, 8'h00, OK);
		wr(pm_pkg::PM_IDX_SEL[1], 8'h02, OK);
		tick(3);
		chk(pad_oe[1], 8'hFF);
		chk(pad_out[1], 8'hFD);
		// port 3 serial: direction from the module, i2c open drain
		pattern <= 8'hA0;
		soe <= 8'hF0;
		wr(pm_pkg::PM_IDX_SEL[2], 8'hFF, OK);
		wr(pm_pkg::PM_IDX_DIR[2], 8'h0F, OK);
		tick(3);
		chk(pad_oe[2], 8'hF0);
		chk(pad_out[2] & 8'hF0, 8'hA0);
		i2c <= 2'h3;
		soe <= 8'hFE;
		pattern <= 8'h02;
		ext[2] <= 8'h01;
		mode <= 2'h3;
		tick(5);
		chk({6'h0, pad_oe[2][2:1]}, 8'h02);
		chk({6'h0, pad_out[2][2:1]}, 8'h00);
		chk({7'h0, sense.spi_four_wire_eff}, 8'h00);
		chk({7'h0, sense.sync_side_slave_enable}, 8'h00);
		chk({7'h0, sense.async_side_serial_clock}, 8'h01);
		mode <= 2'h2;
		tick(5);
		chk({7'h0, sense.spi_four_wire_eff}, 8'h01);
		// port 1 timer inputs and outputs, port 5 release
		wr(pm_pkg::PM_IDX_SEL[0], 8'hFF, OK);
		wr(pm_pkg::PM_IDX_DIR[0], 8'hF0, OK);
		ext[0] <= 8'h0D;
		wr(pm_pkg::PM_IDX_DIR[4], 8'hFF, OK);
		wr(pm_pkg::PM_IDX_SEL[4], 8'h0F, OK);
		tick(3);
		chk(pad_out[0] & 8'hF0, 8'h40);
		chk({4'h0, sense.timer_a_capture_in, sense.first_timer_clock_in}, 8'h0D);
		chk(pad_oe[4], 8'hF0);
		ext[0] <= 8'h00;
		// port 1 and 2 edge flags, mask and clear
		wr(pm_pkg::PM_IDX_DIR[1], 8'h00, OK);
		tick(6);
		for (int k = 0; k < 2; k++) begin
			wr(pm_pkg::PM_IDX_IRQ_FLAGS[k], 8'hFF, OK);
			wr(pm_pkg::PM_IDX_IRQ_EDGE[k], 8'h02, OK);
			wr(pm_pkg::PM_IDX_IRQ_ENABLE[k], 8'h01, OK);
			chk({7'h0, irq}, 8'h00);
			ext[k] <= 8'h03;
			tick(6);
			chk({7'h0, irq}, 8'h01);
			chk({7'h0, sense.timer_a_inclk_in}, 8'(k));
			rd_chk(pm_pkg::PM_IDX_IRQ_FLAGS[k], 8'h01, OK);
			ext[k] <= 8'h00;
			tick(6);
			rd_chk(pm_pkg::PM_IDX_IRQ_FLAGS[k], 8'h03, OK);
			wr(pm_pkg::PM_IDX_IRQ_FLAGS[k], 8'h01, OK);
			tick(2);
			chk({7'h0, irq}, 8'h00);
			rd_chk(pm_pkg::PM_IDX_IRQ_FLAGS[k], 8'h02, OK);
			wr(pm_pkg::PM_IDX_IRQ_FLAGS[k], 8'h02, OK);
		end
		summarize();
	end

endmodule

`default_nettype wire
